/* hw/sfs_axis.sv */
// Per-axis decoder: activation, data set tracking, acknowledge
`timescale 1ns/1ps
`include "sfs_map.svh"
module sfs_axis
	import sfs_pkg::*;
(
	input  wire logic                    core_clk,
	input  wire logic                    sys_rst,
	input  wire logic                    clk_en,
	input  wire logic                    cycle_valid,
	input  wire sfs_pkg::sfs_ctrl_t      ctrl,
	input  wire sfs_pkg::sfs_fmask_t     phys_in_n,
	input  wire sfs_pkg::sfs_fmask_t     phys_conn,
	input  wire sfs_pkg::sfs_fmask_t     bit_map [`SFS_NFUNC],
	input  wire sfs_pkg::sfs_set_t       boot_set,
	input  wire sfs_pkg::sfs_fmask_t     set_valid [`SFS_NFUNC],
	output sfs_pkg::sfs_fmask_t          active,
	output sfs_pkg::sfs_fmask_t          latched,
	output logic [47:0]                  set_idx,
	output sfs_pkg::sfs_word_t           status_word,
	output logic                         safe_state,
	output sfs_pkg::sfs_word_t           error_code
);
	import sfs_pkg::*;

	typedef struct packed {
		sfs_word_t     sel;
		sfs_word_t     sw;
		logic          ack_prev;
		sfs_fmask_t    act;
		sfs_fmask_t    lat;
		logic [47:0]   sets;
		logic [4:0]    err_fn;
		logic [7:0]    last_sw;
		logic          boot_done;
		sfs_axis_st_t  st;
		logic          safe;
		sfs_word_t     err;
	} sfs_axis_state_t;

	sfs_axis_state_t s_r;
	sfs_axis_state_t s_nxt;

	// Decode of a function code into a one-hot function bit
	function automatic sfs_fmask_t code_onehot(input logic [4:0] code);
		sfs_fmask_t m;
		m = '0;
		if (code != 5'h00 && code <= 5'h10)
			m[4'(code - 5'h01)] = 1'b1;
		return m;
	endfunction

	sfs_fmask_t req;
	logic       ack_rise;
	logic [4:0] code;
	sfs_set_t   nset;
	sfs_fmask_t fn_hit;

	// ------------------------------------------------------------
	// Request decode
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < `SFS_NFUNC; g++)
		begin : g_fn
			assign req[g] = (|(s_r.sel & bit_map[g]))
				| (phys_conn[g] & ~phys_in_n[g]);
		end
	endgenerate

	assign ack_rise = s_r.sw[`SFS_ACK_BIT] & ~s_r.ack_prev;
	assign code     = s_r.sw[`SFS_CODE_MSB:`SFS_CODE_LSB];
	assign nset     = s_r.sw[`SFS_SET_MSB:`SFS_SET_LSB];
	assign fn_hit   = code_onehot(code);

	always_comb
	begin
		s_nxt = s_r;
		if (cycle_valid)
		begin
			s_nxt.sel = ctrl.select_word;
			s_nxt.sw  = ctrl.switch_word;
		end
		s_nxt.ack_prev = s_r.sw[`SFS_ACK_BIT];
		s_nxt.act = req;
		// Activation latches until a rising acknowledge while no longer requested
		s_nxt.lat = (s_r.lat & ~({`SFS_NFUNC{ack_rise}} & ~req)) | req;
		if (!s_r.boot_done)
		begin
			s_nxt.sets = {`SFS_NFUNC{boot_set}};
			s_nxt.boot_done = 1'b1;
		end
		else if (nset >= `SFS_SET_MIN)
		begin
			for (int i = 0; i < `SFS_NFUNC; i++)
			begin
				if (fn_hit[i])
				begin
					if (set_valid[i][nset])
					begin
						s_nxt.sets[i*3 +: 3] = nset;
						s_nxt.last_sw = {nset, code};
					end
					else
						s_nxt.err_fn = code;
				end
			end
		end
		s_nxt.st = (|s_nxt.lat) ? SFS_SAFE : SFS_RUN;
		// Registered so that the safe flag and error code leave on flops
		s_nxt.safe = |s_nxt.lat;
		s_nxt.err  = (|s_nxt.lat) ? `SFS_ERR_CODE : `SFS_ERR_NONE;
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			s_r.sel       <= `SFS_WORD_ZERO;
			s_r.sw        <= `SFS_WORD_ZERO;
			s_r.ack_prev  <= 1'b0;
			s_r.act       <= '0;
			s_r.lat       <= '0;
			s_r.sets      <= '0;
			s_r.err_fn    <= '0;
			s_r.last_sw   <= '0;
			s_r.boot_done <= 1'b0;
			s_r.st        <= SFS_RUN;
			s_r.safe      <= 1'b0;
			s_r.err       <= `SFS_ERR_NONE;
		end
		else if (clk_en)
			s_r <= s_nxt;
	end

	assign active      = s_r.act;
	assign latched     = s_r.lat;
	assign set_idx     = s_r.sets;
	assign status_word = {s_r.last_sw, 3'h0, s_r.err_fn};
	assign safe_state  = s_r.safe;
	assign error_code  = s_r.err;

	a_latch_holds: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && req != '0 |=> (s_r.lat & $past(req)) == $past(req))
		else $error("request not latched");
	a_ack_edge: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && !ack_rise && s_r.boot_done |=> (s_r.lat & $past(s_r.lat)) == $past(s_r.lat))
		else $error("latch cleared without ack edge");
	a_safe_state: assert property (@(posedge core_clk) disable iff (sys_rst)
		s_r.lat != '0 |-> safe_state && error_code == `SFS_ERR_CODE)
		else $error("safe state missing");
	a_boot_set: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && !s_r.boot_done |=> s_r.sets[2:0] == $past(boot_set))
		else $error("boot set not loaded");
	a_sample_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && !cycle_valid |=> $stable(s_r.sel) && $stable(s_r.sw))
		else $error("words changed without valid cycle");
	a_set_range: assert property (@(posedge core_clk) disable iff (sys_rst)
		s_r.boot_done && $past(s_r.boot_done) && boot_set != 3'h0 |-> s_r.sets[2:0] != 3'h0)
		else $error("set index zero");
	c_activate: cover property (@(posedge core_clk) req != '0 ##1 s_r.lat != '0);
	c_ack:      cover property (@(posedge core_clk) ack_rise && s_r.lat != '0);
	c_switch:   cover property (@(posedge core_clk) s_r.last_sw != '0);
endmodule

/* pkg/sfs_map.svh */
// Constants for the safety function select decoder
// Summary of operation
// - Configured select word bit activates its function
// - Sixteen independently assignable selection bits per word
// - Physical safety input activates when low
// - Fieldbus selection bit activates when high
// - Physical input or fieldbus bit activates
// - Any of several assigned bits activates
// - One bit may activate several functions
// - Separate select word decoded per axis
// - Separate switch/acknowledge word per axis
// - Data set switch only via second word
// - Switch takes effect without deactivating function
// - Up to seven data sets per function
// - Active data set tracked per function
// - Boot data set used until switchover
// - Boot data set index is configurable
// - Activation forces safe state and error 1013
// - Last accepted switch and rejected function code reported in status word
// - Acknowledge only on rising edge bit 8
// - Low five bits carry function code
// - Bits five to seven carry set index
`ifndef SFS_MAP_SVH
`define SFS_MAP_SVH
`define SFS_NAXES       2
`define SFS_NFUNC       16
`define SFS_WBITS       16
`define SFS_CODE_LSB    0
`define SFS_CODE_MSB    4
`define SFS_SET_LSB     5
`define SFS_SET_MSB     7
`define SFS_ACK_BIT     8
`define SFS_SET_MIN     3'h1
`define SFS_SET_MAX     3'h7
`define SFS_BOOT_RST    3'h1
`define SFS_ERR_CODE    16'h03f5
`define SFS_ERR_NONE    16'h0000
`define SFS_LAST_LSB    8
`define SFS_WORD_ZERO   16'h0000
`endif

/* pkg/sfs_pkg.sv */
// Types for the safety function select decoder
package sfs_pkg;
	typedef logic [15:0] sfs_word_t;
	typedef logic [15:0] sfs_fmask_t;
	typedef logic [2:0]  sfs_set_t;

	typedef struct packed {
		sfs_word_t select_word;
		sfs_word_t switch_word;
	} sfs_ctrl_t;

	typedef enum logic [1:0] {
		SFS_RUN   = 2'b00,
		SFS_SAFE  = 2'b01
	} sfs_axis_st_t;
endpackage

/* hw/sfs_ctrl.sv */
// Two-axis safety function select decoder top
`timescale 1ns/1ps
`include "sfs_map.svh"
module sfs_ctrl
	import sfs_pkg::*;
(
	input  wire logic                core_clk,
	input  wire logic                sys_rst,
	input  wire logic                clk_en,
	input  wire logic                cycle_valid,
	input  wire sfs_pkg::sfs_ctrl_t  ctrl_ax0,
	input  wire sfs_pkg::sfs_ctrl_t  ctrl_ax1,
	input  wire sfs_pkg::sfs_fmask_t phys_in_n_ax0,
	input  wire sfs_pkg::sfs_fmask_t phys_in_n_ax1,
	input  wire sfs_pkg::sfs_fmask_t phys_conn,
	input  wire sfs_pkg::sfs_fmask_t bit_map [`SFS_NFUNC],
	input  wire sfs_pkg::sfs_fmask_t set_valid [`SFS_NFUNC],
	input  wire sfs_pkg::sfs_set_t   boot_set,
	output sfs_pkg::sfs_fmask_t      active_ax0,
	output sfs_pkg::sfs_fmask_t      active_ax1,
	output sfs_pkg::sfs_word_t       status_ax0,
	output sfs_pkg::sfs_word_t       status_ax1,
	output logic [47:0]              sets_ax0,
	output logic [47:0]              sets_ax1,
	output logic                     safe_ax0,
	output logic                     safe_ax1,
	output sfs_pkg::sfs_word_t       err_ax0,
	output sfs_pkg::sfs_word_t       err_ax1
);
	import sfs_pkg::*;

	// Each axis keeps its own words and state
	sfs_axis u_ax0 (
		.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
		.cycle_valid(cycle_valid), .ctrl(ctrl_ax0),
		.phys_in_n(phys_in_n_ax0), .phys_conn(phys_conn), .bit_map(bit_map),
		.boot_set(boot_set), .set_valid(set_valid),
		.active(), .latched(active_ax0), .set_idx(sets_ax0),
		.status_word(status_ax0), .safe_state(safe_ax0), .error_code(err_ax0));
	sfs_axis u_ax1 (
		.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
		.cycle_valid(cycle_valid), .ctrl(ctrl_ax1),
		.phys_in_n(phys_in_n_ax1), .phys_conn(phys_conn), .bit_map(bit_map),
		.boot_set(boot_set), .set_valid(set_valid),
		.active(), .latched(active_ax1), .set_idx(sets_ax1),
		.status_word(status_ax1), .safe_state(safe_ax1), .error_code(err_ax1));
endmodule

/* verif/sfs_master.sv */
// Safety fieldbus master model: sends both control words of each axis
`timescale 1ns/1ps
module sfs_master
(
	output logic               cycle_valid,
	output sfs_pkg::sfs_ctrl_t ctrl_ax0,
	output sfs_pkg::sfs_ctrl_t ctrl_ax1,
	input  wire logic          core_clk
);
	import sfs_pkg::*;
	initial
	begin
		cycle_valid = 1'b1;
		ctrl_ax0 = '0;
		ctrl_ax1 = '0;
	end
	// Bit assignment must match the configured map
	task automatic send_sel(input int ax, input sfs_word_t w);
		@(negedge core_clk);
		if (ax == 0)
			ctrl_ax0.select_word = w;
		else
			ctrl_ax1.select_word = w;
	endtask
	// Acknowledge is only ever given as a fresh 0 to 1 step by the caller
	task automatic send_sw(input int ax, input logic [4:0] fn, input sfs_set_t s, input logic ak);
		@(negedge core_clk);
		if (ax == 0)
			ctrl_ax0.switch_word = {7'h00, ak, s, fn};
		else
			ctrl_ax1.switch_word = {7'h00, ak, s, fn};
	endtask
	task automatic valid(input logic v);
		@(negedge core_clk);
		cycle_valid = v;
	endtask
endmodule

/* verif/tb_sfs_ctrl.sv */
// Self-checking bench for the two-axis safety function select decoder
`timescale 1ns/1ps
module tb_sfs_ctrl;
	import sfs_pkg::*;
	logic        core_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        clk_en = 1'b1;
	logic        cycle_valid;
	sfs_ctrl_t   c0;
	sfs_ctrl_t   c1;
	sfs_fmask_t  pin0 = 16'hffff;
	sfs_fmask_t  pin1 = 16'hffff;
	sfs_fmask_t  conn = 16'h0004;
	sfs_fmask_t  bmap [16];
	sfs_fmask_t  sval [16];
	sfs_set_t    boot = 3'h1;
	sfs_fmask_t  a0;
	sfs_fmask_t  a1;
	sfs_word_t   s0;
	sfs_word_t   s1;
	sfs_word_t   e0;
	sfs_word_t   e1;
	logic [47:0] t0;
	logic [47:0] t1;
	logic        f0;
	logic        f1;
	int          mismatches = 0;
	int          comparisons = 0;
	always #5 core_clk = ~core_clk;
	initial
	begin
		for (int i = 0; i < 16; i++)
		begin
			bmap[i] = 16'h0000;
			sval[i] = 16'h00fe;
		end
		bmap[0] = 16'h0002;
		bmap[3] = 16'h0002;
		bmap[7] = 16'h0100;
		bmap[5] = 16'h0c00;
		bmap[15] = 16'h8000;
		sval[4] = 16'h000e;
	end
	sfs_master sfs_master_inst (.cycle_valid(cycle_valid), .ctrl_ax0(c0), .ctrl_ax1(c1),
		.core_clk(core_clk));
	sfs_ctrl sfs_ctrl_inst (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
		.cycle_valid(cycle_valid), .ctrl_ax0(c0), .ctrl_ax1(c1), .phys_in_n_ax0(pin0),
		.phys_in_n_ax1(pin1), .phys_conn(conn), .bit_map(bmap), .set_valid(sval),
		.boot_set(boot), .active_ax0(a0), .active_ax1(a1), .status_ax0(s0),
		.status_ax1(s1), .sets_ax0(t0), .sets_ax1(t1), .safe_ax0(f0), .safe_ax1(f1),
		.err_ax0(e0), .err_ax1(e1));
	task automatic chk(input string n, input logic [47:0] x, input logic [47:0] g);
		comparisons++;
		if (g !== x)
		begin
			mismatches++;
			$display("[ERR] %s exp %h got %h", n, x, g);
		end
	endtask
	task automatic conclude();
		if (mismatches == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Request to output takes two edges; look one and a half cycles after that
	task automatic settle();
		repeat (3) @(negedge core_clk);
	endtask
	task automatic do_reset();
		@(negedge core_clk);
		sys_rst = 1'b1;
		repeat (3) @(negedge core_clk);
		sys_rst = 1'b0;
		repeat (2) @(negedge core_clk);
	endtask
	task automatic t_select();
		sfs_master_inst.send_sel(0, 16'h0102);
		settle();
		chk("active0", 48'h0089, {32'h0, a0});
		chk("active1", 48'h0, {32'h0, a1});
		chk("safe1", 48'h0, {47'h0, f1});
		chk("safe0", 48'h1, {47'h0, f0});
		chk("err0", 48'h03f5, {32'h0, e0});
		sfs_master_inst.send_sel(0, 16'h8800);
		settle();
		chk("active0", 48'h80a9, {32'h0, a0});
		pin1 = 16'hfffb;
		settle();
		chk("active1", 48'h0004, {32'h0, a1});
		chk("safe1", 48'h1, {47'h0, f1});
		chk("err1", 48'h03f5, {32'h0, e1});
		pin1 = 16'hffff;
	endtask
	task automatic t_switch();
		sfs_master_inst.send_sw(0, 5'h01, 3'h3, 1'b0);
		sfs_master_inst.send_sw(1, 5'h10, 3'h7, 1'b0);
		settle();
		chk("sets0", {{15{3'h1}}, 3'h3}, t0);
		chk("sets1", {3'h7, {15{3'h1}}}, t1);
		chk("active0", 48'h80a9, {32'h0, a0});
		chk("status0", 48'h6100, {32'h0, s0});
		sfs_master_inst.send_sw(0, 5'h01, 3'h0, 1'b0);
		settle();
		chk("sets0", {{15{3'h1}}, 3'h3}, t0);
		sfs_master_inst.send_sw(1, 5'h05, 3'h6, 1'b0);
		settle();
		chk("sets1", {3'h7, {15{3'h1}}}, t1);
		chk("status1", 48'hf005, {32'h0, s1});
	endtask
	task automatic t_ack();
		sfs_master_inst.send_sel(0, 16'h0000);
		sfs_master_inst.valid(1'b0);
		sfs_master_inst.send_sw(0, 5'h01, 3'h3, 1'b1);
		settle();
		chk("active0", 48'h80a9, {32'h0, a0});
		sfs_master_inst.valid(1'b1);
		settle();
		chk("active0", 48'h0, {32'h0, a0});
		chk("err0", 48'h0, {32'h0, e0});
		sfs_master_inst.send_sel(0, 16'h0002);
		settle();
		sfs_master_inst.send_sel(0, 16'h0000);
		settle();
		chk("active0", 48'h0009, {32'h0, a0});
	endtask
	initial
	begin
		repeat (3000) @(posedge core_clk);
		mismatches++;
		conclude();
	end
	initial
	begin
		do_reset();
		chk("sets0", {16{3'h1}}, t0);
		chk("active0", 48'h0, {32'h0, a0});
		t_select();
		t_switch();
		t_ack();
		// Held switch words would be applied again after the reset
		sfs_master_inst.send_sw(0, 5'h00, 3'h0, 1'b0);
		sfs_master_inst.send_sw(1, 5'h00, 3'h0, 1'b0);
		boot = 3'h5;
		do_reset();
		chk("sets0", {16{3'h5}}, t0);
		chk("sets1", {16{3'h5}}, t1);
		chk("safe1", 48'h0, {47'h0, f1});
		chk("status1", 48'h0, {32'h0, s1});
		conclude();
	end
endmodule
